// File: hw/acs_pkg.sv
/*
 * Shared constants and types of the conversion sequencer: register offsets,
 * field positions, reset values, mode and state encodings, converter request.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package acs_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned CH_W   = 4;
	localparam int unsigned SLOT_N = 8;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] NMODE_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] PMODE_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] TRIG_OFS  = 8'h08;
	localparam logic [ADDR_W-1:0] CHAN_OFS  = 8'h0C;
	localparam logic [ADDR_W-1:0] PRES_OFS  = 8'h10;
	localparam logic [2:0]        SLOT_PAGE = 3'h1;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int unsigned N_START_BIT = 0;
	localparam int unsigned MODE_LSB    = 1;
	localparam int unsigned ITM_LSB     = 3;
	localparam int unsigned P_START_BIT = 4;
	localparam int unsigned P_CH_LSB    = 0;
	localparam int unsigned BUSY_BIT    = 6;
	localparam int unsigned DONE_BIT    = 7;
	localparam int unsigned T_NSEL_BIT  = 0;
	localparam int unsigned T_PSEL_BIT  = 1;
	localparam int unsigned T_NEN_BIT   = 2;
	localparam int unsigned T_PEN_BIT   = 3;
	localparam int unsigned T_RST_LSB   = 4;
	localparam int unsigned CH_LAST_LSB = 4;

	// Value written to the soft reset field that clears the sequencer
	localparam logic [1:0] SRST_KEY = 2'h1;

	////////////////////////////////////////////////////////////////////////////
	// Encodings
	typedef enum logic [1:0] {
		MODE_FIX_SGL  = 2'h0,
		MODE_SCAN_SGL = 2'h1,
		MODE_FIX_REP  = 2'h2,
		MODE_SCAN_REP = 2'h3
	} acs_mode_e;

	typedef enum logic [1:0] {
		ITM_EVERY1 = 2'h0,
		ITM_EVERY4 = 2'h1,
		ITM_EVERY8 = 2'h2,
		ITM_RSVD   = 2'h3
	} acs_itm_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_NORM = 3'h2,
		ST_PRIO = 3'h4
	} acs_state_e;

	// Reset values
	localparam acs_mode_e        RST_MODE = MODE_FIX_SGL;
	localparam acs_itm_e         RST_ITM  = ITM_EVERY1;
	localparam logic [CH_W-1:0]  RST_CH   = 4'h0;

	// Request to the analog converter
	typedef struct packed {
		logic            start;
		logic            abort;
		logic [CH_W-1:0] ch;
	} acs_conv_req_s;

endpackage

// File: hw/acs_trig_sel.sv
/*
 * Hardware trigger selector: picks one of two timer events and gates it
 * with its enable. Events are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
module acs_trig_sel (
	input  wire logic ev_a_i,   // Event chosen with select low
	input  wire logic ev_b_i,   // Event chosen with select high
	input  wire logic sel_i,    // Source select
	input  wire logic en_i,     // Hardware triggering allowed
	output logic      trig_o    // Gated trigger pulse
);

	// Combinational: no state, same-clock pulses in and out
	always_comb begin
		trig_o = en_i & (sel_i ? ev_b_i : ev_a_i);
	end

endmodule

// File: hw/acs_result_bank.sv
/*
 * Bank of normal conversion result slots, one write and one read port.
 * Assumes writer and reader run on the same clock.
 */
`timescale 1ns/1ps
module acs_result_bank #(
	parameter int unsigned RES_W = 10,   // Result width
	parameter int unsigned DEPTH = 8     // Number of slots
) (
	input  wire logic                     mclk_i,   // System clock
	input  wire logic                     rst_i,    // Sync reset, high
	input  wire logic                     we_i,     // Store a result
	input  wire logic [$clog2(DEPTH)-1:0] widx_i,   // Slot written
	input  wire logic [RES_W-1:0]         wdata_i,  // Result written
	input  wire logic [$clog2(DEPTH)-1:0] ridx_i,   // Slot read
	output logic      [RES_W-1:0]         rdata_o   // Slot contents
);

	logic [RES_W-1:0] mem_q [DEPTH];

	// Slots clear on reset so software never reads stale junk
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (we_i) begin
			mem_q[widx_i] <= wdata_i;
		end
	end

	// Asynchronous read, registered by the bus slave
	always_comb begin
		rdata_o = mem_q[ridx_i];
	end

endmodule

// File: hw/acs_sequencer.sv
/*
 * Conversion sequencer: APB register file, normal and high-priority
 * conversion control, result slot steering and completion pulses.
 * Assumes timers and the analog converter run on mclk_i; the converter
 * drops a conversion on abort and pulses done once per started conversion.
 */
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int unsigned RES_W = 10   // Converter result width
) (
	input  wire logic                      mclk_i,        // 20 MHz system clock
	input  wire logic                      rst_i,         // Sync reset, high
	input  wire logic                      psel_i,        // APB select
	input  wire logic                      penable_i,     // APB access phase
	input  wire logic                      pwrite_i,      // APB write
	input  wire logic [acs_pkg::ADDR_W-1:0] paddr_i,      // APB byte address
	input  wire logic [31:0]               pwdata_i,      // APB write data
	output logic      [31:0]               prdata_o,      // APB read data
	output logic                           pready_o,      // APB ready
	output logic                           pslverr_o,     // Unmapped address
	input  wire logic                      timer0_event_a_i, // Timer 0 event a
	input  wire logic                      timer0_event_b_i, // Timer 0 event b
	input  wire logic                      timer9_event_b_i, // Timer 9 event b
	output acs_pkg::acs_conv_req_s         conv_req_o,    // Converter request
	input  wire logic                      conv_done_i,   // Conversion finished
	input  wire logic [RES_W-1:0]          conv_result_i, // Result with done
	output logic                           conversion_done_irq_o, // Normal pulse
	output logic                           priority_done_irq_o    // Priority pulse
);

	import acs_pkg::*;

	localparam int unsigned SLOT_W = $clog2(SLOT_N);

	typedef struct packed {
		acs_state_e      st;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
		acs_mode_e       mode;
		acs_itm_e        itm;
		logic [CH_W-1:0] base_ch;
		logic [CH_W-1:0] last_ch;
		logic [CH_W-1:0] p_ch;
		logic [CH_W-1:0] cur_ch;
		logic            ntsel;
		logic            ptsel;
		logic            nhwen;
		logic            phwen;
		logic            busy_n;
		logic            done_n;
		logic            busy_p;
		logic            done_p;
		logic [2:0]      cnt;
		logic [RES_W-1:0] p_res;
		acs_conv_req_s   req;
		logic            irq_n;
		logic            irq_p;
	} acs_state_s;

	acs_state_s s_q;
	acs_state_s s_d;

	logic              trig_n;
	logic              trig_p;
	logic              res_we;
	logic [SLOT_W-1:0] res_widx;
	logic [RES_W-1:0]  slot_rdata;

	// Mapped address test, shared by read data and error answer
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == NMODE_OFS) || (a == PMODE_OFS) || (a == TRIG_OFS) ||
			(a == CHAN_OFS) || (a == PRES_OFS) ||
			((a[7:5] == SLOT_PAGE) && (a[1:0] == 2'h0));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Timer trigger selection
	acs_trig_sel u_trig_n (
		.ev_a_i (timer0_event_a_i),
		.ev_b_i (timer0_event_b_i),
		.sel_i  (s_q.ntsel),
		.en_i   (s_q.nhwen),
		.trig_o (trig_n)
	);

	acs_trig_sel u_trig_p (
		.ev_a_i (timer0_event_b_i),
		.ev_b_i (timer9_event_b_i),
		.sel_i  (s_q.ptsel),
		.en_i   (s_q.phwen),
		.trig_o (trig_p)
	);

	acs_result_bank #(
		.RES_W (RES_W),
		.DEPTH (SLOT_N)
	) u_bank (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.we_i    (res_we),
		.widx_i  (res_widx),
		.wdata_i (conv_result_i),
		.ridx_i  (paddr_i[4:2]),
		.rdata_o (slot_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode and sequencing, one combinational pass
	logic apb_setup;
	logic apb_acc;
	logic wr_nmode;
	logic wr_pmode;
	logic rd_nmode;
	logic rd_pmode;
	logic srst;
	logic n_go;
	logic p_go;
	logic fixed_rep;
	logic grp_end;
	logic n_last;
	logic rep_now;

	always_comb begin
		s_d = s_q;
		s_d.req.start = 1'b0;
		s_d.req.abort = 1'b0;
		s_d.irq_n     = 1'b0;
		s_d.irq_p     = 1'b0;
		res_we        = 1'b0;
		res_widx      = '0;
		grp_end       = 1'b0;
		n_last        = 1'b0;

		apb_setup = psel_i & ~penable_i;
		apb_acc   = psel_i & penable_i & s_q.pready;
		wr_nmode  = apb_acc & pwrite_i & (paddr_i == NMODE_OFS);
		wr_pmode  = apb_acc & pwrite_i & (paddr_i == PMODE_OFS);
		rd_nmode  = apb_acc & ~pwrite_i & (paddr_i == NMODE_OFS);
		rd_pmode  = apb_acc & ~pwrite_i & (paddr_i == PMODE_OFS);
		srst      = apb_acc & pwrite_i & (paddr_i == TRIG_OFS) &&
			(pwdata_i[T_RST_LSB +: 2] == SRST_KEY);

		// Software and hardware starts are ORed, so neither masks the other
		n_go = ((wr_nmode & pwdata_i[N_START_BIT]) | trig_n) &
			~s_q.busy_n & ~s_q.busy_p;
		p_go = ((wr_pmode & pwdata_i[P_START_BIT]) | trig_p) &
			~s_q.busy_p;

		// Zero-wait slave: ready and data are registered in the setup cycle
		s_d.pready  = apb_setup;
		s_d.pslverr = apb_setup & ~is_mapped(paddr_i);
		if (apb_setup && !pwrite_i) begin
			s_d.prdata = 32'h0000_0000;
			if (paddr_i == NMODE_OFS) begin
				s_d.prdata[MODE_LSB +: 2] = s_q.mode;
				s_d.prdata[ITM_LSB +: 2]  = s_q.itm;
				s_d.prdata[BUSY_BIT]      = s_q.busy_n;
				s_d.prdata[DONE_BIT]      = s_q.done_n;
			end else if (paddr_i == PMODE_OFS) begin
				s_d.prdata[P_CH_LSB +: CH_W] = s_q.p_ch;
				s_d.prdata[BUSY_BIT]         = s_q.busy_p;
				s_d.prdata[DONE_BIT]         = s_q.done_p;
			end else if (paddr_i == TRIG_OFS) begin
				s_d.prdata[T_NSEL_BIT] = s_q.ntsel;
				s_d.prdata[T_PSEL_BIT] = s_q.ptsel;
				s_d.prdata[T_NEN_BIT]  = s_q.nhwen;
				s_d.prdata[T_PEN_BIT]  = s_q.phwen;
			end else if (paddr_i == CHAN_OFS) begin
				s_d.prdata[CH_W-1:0]            = s_q.base_ch;
				s_d.prdata[CH_LAST_LSB +: CH_W] = s_q.last_ch;
			end else if (paddr_i == PRES_OFS) begin
				s_d.prdata[RES_W-1:0] = s_q.p_res;
			end else if (is_mapped(paddr_i)) begin
				s_d.prdata[RES_W-1:0] = slot_rdata;
			end
		end

		// Configuration writes
		if (wr_nmode) begin
			s_d.mode = acs_mode_e'(pwdata_i[MODE_LSB +: 2]);
			s_d.itm  = acs_itm_e'(pwdata_i[ITM_LSB +: 2]);
		end
		if (wr_pmode) begin
			s_d.p_ch = pwdata_i[P_CH_LSB +: CH_W];
		end
		if (apb_acc && pwrite_i && paddr_i == TRIG_OFS) begin
			s_d.ntsel = pwdata_i[T_NSEL_BIT];
			s_d.ptsel = pwdata_i[T_PSEL_BIT];
			s_d.nhwen = pwdata_i[T_NEN_BIT];
			s_d.phwen = pwdata_i[T_PEN_BIT];
		end
		if (apb_acc && pwrite_i && paddr_i == CHAN_OFS) begin
			s_d.base_ch = pwdata_i[CH_W-1:0];
			s_d.last_ch = pwdata_i[CH_LAST_LSB +: CH_W];
		end

		// Done flags clear on read; a set in the same cycle wins below.
		// Only a one that software has actually seen is cleared, so a done
		// set between setup and access is not lost.
		if (rd_nmode && s_q.prdata[DONE_BIT]) begin
			s_d.done_n = 1'b0;
		end
		if (rd_pmode && s_q.prdata[DONE_BIT]) begin
			s_d.done_p = 1'b0;
		end

		fixed_rep = (s_d.mode == MODE_FIX_REP);
		rep_now   = s_d.mode[1];

		// Normal start latches the sequence origin
		if (n_go) begin
			s_d.busy_n = 1'b1;
			s_d.cur_ch = s_q.base_ch;
			s_d.cnt    = 3'h0;
		end

		unique case (s_q.st)
			ST_IDLE, ST_NORM: begin
				if (p_go) begin
					// Abort normal work; cur_ch and busy_n stay put
					s_d.busy_p    = 1'b1;
					s_d.req.abort = (s_q.st == ST_NORM);
					s_d.req.start = 1'b1;
					s_d.req.ch    = s_d.p_ch;
					s_d.st        = ST_PRIO;
				end else if (n_go) begin
					s_d.req.start = 1'b1;
					s_d.req.ch    = s_q.base_ch;
					s_d.st        = ST_NORM;
				end else if (s_q.st == ST_NORM && conv_done_i && !s_q.req.start) begin
					// Slot steering: fixed repeat cycles slots, others map channel
					res_we = 1'b1;
					if (fixed_rep) begin
						unique case (s_d.itm)
							ITM_EVERY1: begin
								res_widx = '0;
								grp_end  = 1'b1;
							end
							ITM_EVERY4: begin
								res_widx = {1'b0, s_q.cnt[1:0]};
								grp_end  = (s_q.cnt[1:0] == 2'h3);
							end
							ITM_EVERY8, ITM_RSVD: begin
								res_widx = s_q.cnt;
								grp_end  = (s_q.cnt == 3'h7);
							end
						endcase
						s_d.cnt = grp_end ? 3'h0 : s_q.cnt + 3'h1;
					end else begin
						res_widx = s_q.cur_ch[SLOT_W-1:0];
						n_last   = ~s_d.mode[0] || (s_q.cur_ch == s_q.last_ch);
						grp_end  = n_last;
					end
					if (grp_end) begin
						s_d.done_n = 1'b1;
						s_d.irq_n  = 1'b1;
					end
					// Repeat cleared: stop after this conversion (or this scan)
					if (!rep_now && (fixed_rep || !s_d.mode[0] || n_last)) begin
						s_d.busy_n = 1'b0;
						s_d.st     = ST_IDLE;
					end else begin
						if (s_d.mode[0]) begin
							s_d.cur_ch = n_last ? s_q.base_ch : s_q.cur_ch + 4'h1;
						end
						s_d.req.start = 1'b1;
						s_d.req.ch    = s_d.cur_ch;
					end
				end
			end
			ST_PRIO: begin
				// A done beside our own start belongs to the aborted conversion
				if (conv_done_i && !s_q.req.start) begin
					s_d.p_res  = conv_result_i;
					s_d.done_p = 1'b1;
					s_d.irq_p  = 1'b1;
					s_d.busy_p = 1'b0;
					if (s_q.busy_n) begin
						// Redo the channel that was cut short
						s_d.req.start = 1'b1;
						s_d.req.ch    = s_q.cur_ch;
						s_d.st        = ST_NORM;
					end else begin
						s_d.st = ST_IDLE;
					end
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Soft reset stops everything but keeps configuration
		if (srst) begin
			s_d.req.abort = (s_q.st != ST_IDLE);
			s_d.req.start = 1'b0;
			s_d.busy_n    = 1'b0;
			s_d.busy_p    = 1'b0;
			s_d.done_n    = 1'b0;
			s_d.done_p    = 1'b0;
			s_d.st        = ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_q         <= '0;
			s_q.st      <= ST_IDLE;
			s_q.mode    <= RST_MODE;
			s_q.itm     <= RST_ITM;
			s_q.base_ch <= RST_CH;
			s_q.last_ch <= RST_CH;
			s_q.p_ch    <= RST_CH;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		prdata_o              = s_q.prdata;
		pready_o              = s_q.pready;
		pslverr_o             = s_q.pslverr;
		conv_req_o            = s_q.req;
		conversion_done_irq_o = s_q.irq_n;
		priority_done_irq_o   = s_q.irq_p;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	property p_nstart;
		n_go && !srst |=> s_q.busy_n;
	endproperty
	a_nstart: assert property (p_nstart) else $error("normal busy not set");

	property p_pstart;
		p_go && !srst |=> s_q.busy_p && s_q.req.start && s_q.st == ST_PRIO;
	endproperty
	a_pstart: assert property (p_pstart) else $error("priority start lost");

	property p_preempt;
		s_q.st == ST_NORM && p_go && !srst |=> s_q.req.abort && s_q.req.ch == s_q.p_ch
			&& s_q.cur_ch == $past(s_q.cur_ch);
	endproperty
	a_preempt: assert property (p_preempt) else $error("pre-emption wrong");

	property p_hold;
		s_q.st == ST_PRIO && !srst |=> $stable(s_q.busy_n) && $stable(s_q.cur_ch);
	endproperty
	a_hold: assert property (p_hold) else $error("normal state moved");

	property p_ignore;
		s_q.st == ST_PRIO && !conv_done_i && !srst |=> !s_q.req.start && !s_q.req.abort;
	endproperty
	a_ignore: assert property (p_ignore) else $error("second priority taken");

	property p_pdone;
		s_q.st == ST_PRIO && conv_done_i && !s_q.req.start && !srst |=>
			s_q.done_p && !s_q.busy_p && s_q.irq_p ##1 !s_q.irq_p;
	endproperty
	a_pdone: assert property (p_pdone) else $error("priority completion wrong");

	property p_resume;
		s_q.st == ST_PRIO && conv_done_i && !s_q.req.start && s_q.busy_n && !srst |=>
			s_q.req.start && s_q.req.ch == $past(s_q.cur_ch);
	endproperty
	a_resume: assert property (p_resume) else $error("resume channel wrong");

	property p_single;
		s_q.st == ST_NORM && conv_done_i && !s_q.req.start && !p_go && !srst && s_d.mode == MODE_FIX_SGL |=>
			s_q.done_n && !s_q.busy_n && s_q.irq_n;
	endproperty
	a_single: assert property (p_single) else $error("single end wrong");

	property p_slot1;
		res_we && fixed_rep && s_d.itm == ITM_EVERY1 && !srst |-> res_widx == 3'h0 ##1 s_q.done_n && s_q.irq_n;
	endproperty
	a_slot1: assert property (p_slot1) else $error("slot one not used");

	property p_rdclr;
		rd_nmode && s_q.prdata[DONE_BIT] && !s_d.irq_n |=> !s_q.done_n;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("done not cleared");

	c_preempt: cover property (s_q.st == ST_NORM && p_go);
	c_rep8: cover property (res_we && fixed_rep && res_widx == 3'h7);
	c_scan: cover property (s_q.irq_n && s_q.mode == MODE_SCAN_REP);

endmodule

// File: bench/acs_conv_model.sv
/*
 * Behavioural analog converter facing the sequencer's converter port.
 * Assumes requests arrive registered on mclk_i; one done pulse per start.
 */
`timescale 1ns/1ps
module acs_conv_model
	import acs_pkg::*;
#(
	parameter int unsigned RES_W = 10,  // Result width
	parameter int unsigned LAT   = 12   // Cycles per conversion
) (
	input  wire logic                   mclk_i,    // System clock
	input  wire logic                   rst_i,     // Sync reset, high
	input  wire acs_pkg::acs_conv_req_s req_i,     // Request from sequencer
	input  wire logic                   slow_i,    // Triple conversion time
	output logic                        done_o,    // Finished pulse
	output logic      [RES_W-1:0]       result_o   // Result, junk outside done
);
	logic [7:0]       cnt_q;
	logic             run_q;
	logic [3:0]       ch_q;
	logic [3:0]       tag_q;
	logic [RES_W-1:0] last_q;

	////////////////////////////////////////////////////////////////////////////
	// A new start always wins over an abort: the sequencer restarts at once
	always_ff @(posedge mclk_i) begin
		done_o <= 1'b0;
		if (rst_i) begin
			run_q  <= 1'b0;
			tag_q  <= '0;
			cnt_q  <= '0;
			ch_q   <= '0;
			last_q <= '0;
		end else if (req_i.start) begin
			run_q <= 1'b1;
			ch_q  <= req_i.ch;
			cnt_q <= slow_i ? 8'(3*LAT) : 8'(LAT);
		end else if (req_i.abort) begin
			run_q <= 1'b0;  // Aborted conversion gives no done
		end else if (run_q && cnt_q == 8'h01) begin
			run_q  <= 1'b0;
			done_o <= 1'b1;
			tag_q  <= tag_q + 4'h1;
			last_q <= RES_W'({tag_q, ch_q});  // Tag shows order of completion
		end else if (run_q) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// Outside done the bus shows no stale result
	assign result_o = done_o ? last_q : ~last_q;
endmodule

// File: bench/tb_top.sv
/*
 * Self-checking bench of the conversion sequencer over APB.
 * Assumes the converter model of this folder and a 20 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
	import acs_pkg::*;
	logic          mclk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]    paddr = '0;
	logic [31:0]   pwdata = '0, prdata, rd;
	logic          pready, pslverr, err, ev_a = 0, ev_b = 0, ev_c = 0, slow = 0;
	logic          cdone, nirq, pirq;
	logic [9:0]    cres;
	acs_conv_req_s req;
	int            num_errors = 0, n_compared = 0;
	int            n_start = 0, n_abort = 0, n_nirq = 0, n_pirq = 0;
	logic [3:0]    last_ch = '0, ch_b;

	always #25 mclk_i = ~mclk_i;

	acs_sequencer uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.timer0_event_a_i(ev_a), .timer0_event_b_i(ev_b), .timer9_event_b_i(ev_c), .conv_req_o(req),
		.conv_done_i(cdone), .conv_result_i(cres), .conversion_done_irq_o(nirq), .priority_done_irq_o(pirq));
	acs_conv_model conv (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .slow_i(slow), .done_o(cdone),
		.result_o(cres));

	// Counts converter requests and completion pulses on the falling edge,
	// where outputs launched at the rising edge have settled
	always @(negedge mclk_i) begin
		if (req.start === 1'b1) begin
			n_start++;
			last_ch = req.ch;
		end
		if (req.abort === 1'b1) n_abort++;
		if (nirq === 1'b1) n_nirq++;
		if (pirq === 1'b1) n_pirq++;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("Counts: %0d compared, %0d mismatched", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer, entered right after a rising edge; holds until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			num_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wait_irq(input bit prio);
		int b, i;
		b = prio ? n_pirq : n_nirq;
		for (i = 0; i < 2000 && (prio ? n_pirq : n_nirq) == b; i++) @(posedge mclk_i);
		if (i >= 2000) begin
			num_errors++;
			give_verdict();
		end
	endtask

	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		rst_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_idle;
		do_reset();
		apb(0, NMODE_OFS, 0); chk("nmode flags", rd[7:6], 0);
		apb(0, PMODE_OFS, 0); chk("pmode flags", rd[7:6], 0);
		apb(0, 8'h44, 0); chk("unmapped err", err, 1);
		chk("unmapped read", rd, 0);
		$display("test idle done");
	endtask

	task automatic t_single;
		do_reset();
		apb(1, CHAN_OFS, 32'h33);
		apb(1, NMODE_OFS, 32'h1);
		apb(0, NMODE_OFS, 0); chk("busy on start", rd[6], 1);
		chk("start channel", last_ch, 3);
		wait_irq(0);
		apb(0, NMODE_OFS, 0); chk("done busy", rd[7:6], 2'b10);
		apb(0, NMODE_OFS, 0); chk("done after read", rd[7], 0);
		apb(0, 8'h2C, 0); chk("slot 3", rd, 32'h3);
		$display("test single done");
	endtask

	// Fixed repeat with a given interval code and ring size
	task automatic t_rep(input logic [1:0] itm, input int n);
		int i, s;
		do_reset();
		slow <= (itm == 2'h2);
		apb(1, CHAN_OFS, 32'h55);
		apb(1, NMODE_OFS, {27'h0, itm, 2'b10, 1'b1});
		wait_irq(0);
		for (i = 0; i < n; i++) begin
			apb(0, 8'h20 + 8'(4*i), 0); chk("ring slot", rd, 32'(i*16 + 5));
		end
		if (n < 8) begin
			apb(0, 8'h20 + 8'(4*n), 0); chk("slot past ring", rd, 0);
		end
		apb(0, NMODE_OFS, 0); chk("repeat busy", rd[7:6], 2'b11);
		apb(1, NMODE_OFS, 32'h0);
		for (i = 0; i < 400 && rd[6] !== 1'b0; i++) apb(0, NMODE_OFS, 0);
		chk("busy after stop", rd[6], 0);
		s = n_start;
		repeat (40) @(posedge mclk_i);
		chk("no restart", n_start, s);
		slow <= 1'b0;
		$display("test repeat %0d done", n);
	endtask

	task automatic t_preempt;
		int s;
		do_reset();
		apb(1, CHAN_OFS, 32'h30);
		apb(1, NMODE_OFS, 32'h7);
		wait_irq(0);
		apb(0, NMODE_OFS, 0); chk("scan repeat flags", rd[7:6], 2'b11);
		repeat (3) @(posedge mclk_i);
		ch_b = last_ch;
		s = n_abort;
		apb(1, PMODE_OFS, 32'h1F);
		chk("abort sent", n_abort, s + 1);
		chk("prio channel", last_ch, 15);
		apb(0, PMODE_OFS, 0); chk("prio busy", rd[6], 1);
		apb(0, NMODE_OFS, 0); chk("normal busy kept", rd[6], 1);
		apb(1, PMODE_OFS, 32'h13);
		chk("second prio ignored", n_abort, s + 1);
		chk("prio channel kept", last_ch, 15);
		wait_irq(1);
		@(posedge mclk_i);
		chk("resume channel", last_ch, ch_b);
		apb(0, PMODE_OFS, 0); chk("prio done", rd[7:6], 2'b10);
		apb(0, PMODE_OFS, 0); chk("prio done cleared", rd[7], 0);
		apb(0, PRES_OFS, 0); chk("prio result", rd[3:0], 4'hF);
		apb(1, TRIG_OFS, 32'h10);
		apb(0, NMODE_OFS, 0); chk("soft reset busy", rd[6], 0);
		$display("test preempt done");
	endtask

	task automatic t_hw;
		int s, p;
		do_reset();
		apb(1, CHAN_OFS, 32'h21);
		apb(1, PMODE_OFS, 32'h9);
		apb(1, NMODE_OFS, 32'h2);
		apb(1, TRIG_OFS, 32'hC);
		s = n_start;
		ev_a <= 1'b1;
		@(posedge mclk_i);
		ev_a <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("hw normal start", n_start, s + 1);
		chk("hw normal channel", last_ch, 1);
		s = n_abort;
		p = n_pirq;
		ev_b <= 1'b1;
		@(posedge mclk_i);
		ev_b <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("hw prio start", n_abort, s + 1);
		chk("hw prio channel", last_ch, 9);
		wait_irq(0);
		chk("prio before normal", n_pirq, p + 1);
		apb(0, NMODE_OFS, 0); chk("scan single flags", rd[7:6], 2'b10);
		s = n_start;
		apb(1, NMODE_OFS, 32'h3);
		@(posedge mclk_i);
		chk("sw start with hw", n_start, s + 1);
		apb(1, TRIG_OFS, 32'hA);
		s = n_abort;
		ev_c <= 1'b1;
		@(posedge mclk_i);
		ev_c <= 1'b0;
		repeat (2) @(posedge mclk_i);
		chk("timer9 prio abort", n_abort, s + 1);
		chk("timer9 prio channel", last_ch, 9);
		$display("test hardware done");
	endtask

	initial begin
		t_idle();
		t_single();
		t_rep(2'h0, 1);
		t_rep(2'h1, 4);
		t_rep(2'h2, 8);
		t_preempt();
		t_hw();
		give_verdict();
	end
endmodule
